// File: gpcb_bank.sv
// pin configuration bank: config registers and pad control for six pins
// assumes remote and functional values come from logic on clk
//
// Behaviour
// R1: {direction, enable} 00 functional, 10 tri-state, 01 output, 11 input.
// R2: a general output pin without remote control drives its local value.
// R3: a pin with remote control set is an output carrying the far value.
// R4: with remote control clear the far value is ignored, local settings rule.
// R5: upper pin in bits 7:4, lower in 3:0, each value, remote, dir, enable.
// R6: second-port select set steers the pin-3 register to the second pin 3.
// R7: a register write reaches the pin in the cycle after the write is taken.
module gpcb_bank (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // port steering
  input wire logic second_port_select,
  // pin sources
  input wire logic [gpcb_pkg::PIN_COUNT-1:0] func_value,
  input wire logic [gpcb_pkg::PIN_COUNT-1:0] remote_value,
  // pads
  input wire logic [gpcb_pkg::PIN_COUNT-1:0] pin_in,
  output logic [gpcb_pkg::PIN_COUNT-1:0] pin_out,
  output logic [gpcb_pkg::PIN_COUNT-1:0] pin_oe
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [3:0] pin3_config_reg, pin3_config_next;
  logic [3:0] second_config_reg, second_config_next;
  logic [7:0] pin56_config_reg, pin56_config_next;
  logic [7:0] pin78_config_reg, pin78_config_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [gpcb_pkg::PIN_COUNT-1:0] level_reg, level_next;
  logic [gpcb_pkg::PIN_COUNT-1:0] sync1_reg, sync2_reg, sync3_reg;
  logic [gpcb_pkg::PIN_COUNT-1:0] pin_out_reg, pin_out_next;
  logic [gpcb_pkg::PIN_COUNT-1:0] pin_oe_reg, pin_oe_next;
  logic [gpcb_pkg::PIN_COUNT-1:0] agree;
  gpcb_pkg::gpcb_pin_cfg_type cfg [gpcb_pkg::PIN_COUNT];

  always_comb
  begin
    pin3_config_next = pin3_config_reg;
    second_config_next = second_config_reg;
    pin56_config_next = pin56_config_reg;
    pin78_config_next = pin78_config_reg;
    rdata_next = 8'h00;
    if (reg_wr)
    begin
      unique case (reg_addr)
        gpcb_pkg::PIN3_CONFIG_ADDR:
        begin
          // upper nibble is reserved and stays zero
          if (second_port_select)
            second_config_next = reg_wdata[3:0]; // R6
          else
            pin3_config_next = reg_wdata[3:0];
        end
        gpcb_pkg::PIN56_CONFIG_ADDR: pin56_config_next = reg_wdata;
        gpcb_pkg::PIN78_CONFIG_ADDR: pin78_config_next = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        gpcb_pkg::PIN3_CONFIG_ADDR:
          rdata_next = second_port_select ? {4'h0, second_config_reg}
                                          : {4'h0, pin3_config_reg}; // R6
        gpcb_pkg::PIN56_CONFIG_ADDR: rdata_next = pin56_config_reg;
        gpcb_pkg::PIN78_CONFIG_ADDR: rdata_next = pin78_config_reg;
        gpcb_pkg::PIN_LEVEL_ADDR: rdata_next = {2'h0, level_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pin3_config_reg <= gpcb_pkg::PIN3_CONFIG_RESET[3:0];
      second_config_reg <= gpcb_pkg::PIN3_CONFIG_RESET[3:0];
      pin56_config_reg <= gpcb_pkg::PIN56_CONFIG_RESET;
      pin78_config_reg <= gpcb_pkg::PIN78_CONFIG_RESET;
      rdata_reg <= 8'h00;
    end
    else
    begin
      pin3_config_reg <= pin3_config_next;
      second_config_reg <= second_config_next;
      pin56_config_reg <= pin56_config_next;
      pin78_config_reg <= pin78_config_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // nibble per pin slot
  // ----------------------------------------------------------------
  assign cfg[gpcb_pkg::SLOT_PIN3] = pin3_config_reg;
  assign cfg[gpcb_pkg::SLOT_PIN5] =
    pin56_config_reg[gpcb_pkg::LOW_PIN_LSB +: gpcb_pkg::NIBBLE_W]; // R5
  assign cfg[gpcb_pkg::SLOT_PIN6] =
    pin56_config_reg[gpcb_pkg::HIGH_PIN_LSB +: gpcb_pkg::NIBBLE_W]; // R5
  assign cfg[gpcb_pkg::SLOT_PIN7] =
    pin78_config_reg[gpcb_pkg::LOW_PIN_LSB +: gpcb_pkg::NIBBLE_W]; // R5
  assign cfg[gpcb_pkg::SLOT_PIN8] =
    pin78_config_reg[gpcb_pkg::HIGH_PIN_LSB +: gpcb_pkg::NIBBLE_W]; // R5
  assign cfg[gpcb_pkg::SLOT_SECOND_PIN3] = second_config_reg; // R6

  // ----------------------------------------------------------------
  // pad drive, one stage after the config registers
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < gpcb_pkg::PIN_COUNT; g++)
    begin : g_pin
      always_comb
      begin
        pin_out_next[g] = 1'b0;
        pin_oe_next[g] = 1'b0;
        if (cfg[g].remote_ctrl)
        begin
          pin_oe_next[g] = 1'b1; // R3
          pin_out_next[g] = remote_value[g]; // R3
        end
        else
        begin
          // far value never reaches the pad on this path
          unique case (gpcb_pkg::gpcb_mode_type'({cfg[g].direction,
                                                   cfg[g].general_enable}))
            gpcb_pkg::MODE_FUNCTIONAL:
            begin
              pin_oe_next[g] = 1'b1; // R1 R4
              pin_out_next[g] = func_value[g]; // R4
            end
            gpcb_pkg::MODE_GP_OUTPUT:
            begin
              pin_oe_next[g] = 1'b1; // R1
              pin_out_next[g] = cfg[g].local_value; // R2
            end
            gpcb_pkg::MODE_TRISTATE: pin_oe_next[g] = 1'b0; // R1
            gpcb_pkg::MODE_GP_INPUT: pin_oe_next[g] = 1'b0; // R1
          endcase
        end
      end
    end
  endgenerate

  // filtered input: a change counts once stages two and three agree
  assign agree = ~(sync2_reg ^ sync3_reg);
  assign level_next = (agree & sync3_reg) | (~agree & level_reg);

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pin_out_reg <= '0;
      pin_oe_reg <= '0;
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      level_reg <= '0;
    end
    else
    begin
      pin_out_reg <= pin_out_next; // R7
      pin_oe_reg <= pin_oe_next; // R7
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      level_reg <= level_next;
    end
  end

  assign pin_out = pin_out_reg;
  assign pin_oe = pin_oe_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  property p_tristate;
    (!cfg[2].remote_ctrl && cfg[2].direction && !cfg[2].general_enable)
      |=> !pin_oe[2];
  endproperty
  a_tristate: assert property (p_tristate) // R1
    else $error("tri-state pin still driven");

  property p_local_out;
    (!cfg[1].remote_ctrl && !cfg[1].direction && cfg[1].general_enable)
      |=> pin_oe[1] && pin_out[1] == $past(cfg[1].local_value);
  endproperty
  a_local_out: assert property (p_local_out) // R2
    else $error("local value not on pin");

  property p_remote;
    cfg[4].remote_ctrl |=> pin_oe[4] && pin_out[4] == $past(remote_value[4]);
  endproperty
  a_remote: assert property (p_remote) // R3
    else $error("remote value not on pin");

  property p_functional;
    (!cfg[3].remote_ctrl && !cfg[3].direction && !cfg[3].general_enable)
      |=> pin_oe[3] && pin_out[3] == $past(func_value[3]);
  endproperty
  a_functional: assert property (p_functional) // R4
    else $error("functional value not on pin");

  property p_high_nibble;
    (reg_wr && reg_addr == gpcb_pkg::PIN56_CONFIG_ADDR && reg_wdata[6])
      ##1 !reg_wr |=> pin_oe[2] && pin_out[2] == $past(remote_value[2]);
  endproperty
  a_high_nibble: assert property (p_high_nibble) // R5
    else $error("bit 6 did not steer the upper pin");

  property p_second_port;
    (reg_wr && reg_addr == gpcb_pkg::PIN3_CONFIG_ADDR && second_port_select)
      |=> second_config_reg == $past(reg_wdata[3:0]) &&
          $stable(pin3_config_reg);
  endproperty
  a_second_port: assert property (p_second_port) // R6
    else $error("pin-3 write missed the second port");

  property p_write_latency;
    (reg_wr && reg_addr == gpcb_pkg::PIN78_CONFIG_ADDR) ##1 1'b1
      |=> pin_oe[3] == ($past(reg_wdata[2], 2) || !$past(reg_wdata[1], 2));
  endproperty
  a_write_latency: assert property (p_write_latency) // R7
    else $error("write not on pin one cycle later");

  property p_readback;
    (reg_rd && reg_addr == gpcb_pkg::PIN78_CONFIG_ADDR)
      |=> reg_rdata == $past(pin78_config_reg);
  endproperty
  a_readback: assert property (p_readback) // R5
    else $error("readback differs from register");

  c_remote: cover property (cfg[0].remote_ctrl ##1 pin_oe[0]);
  c_second: cover property (reg_wr && second_port_select &&
                            reg_addr == gpcb_pkg::PIN3_CONFIG_ADDR);
  c_input: cover property (cfg[1].direction && cfg[1].general_enable &&
                           !cfg[1].remote_ctrl);

endmodule

// File: gpcb_pkg.sv
// constants and types for the pin configuration bank
// assumes a byte-wide register port and six pin slots
package gpcb_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PIN3_CONFIG_ADDR = 8'h1f;
  localparam logic [7:0] PIN56_CONFIG_ADDR = 8'h20;
  localparam logic [7:0] PIN78_CONFIG_ADDR = 8'h21;
  localparam logic [7:0] PIN_LEVEL_ADDR = 8'h24;

  localparam logic [7:0] PIN3_CONFIG_RESET = 8'h02;
  localparam logic [7:0] PIN56_CONFIG_RESET = 8'h00;
  localparam logic [7:0] PIN78_CONFIG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // field layout inside one register
  // ----------------------------------------------------------------
  localparam int LOW_PIN_LSB = 0;
  localparam int HIGH_PIN_LSB = 4;
  localparam int NIBBLE_W = 4;
  localparam int VALUE_BIT = 3;
  localparam int REMOTE_BIT = 2;
  localparam int DIR_BIT = 1;
  localparam int EN_BIT = 0;

  // ----------------------------------------------------------------
  // pin slots
  // ----------------------------------------------------------------
  localparam int PIN_COUNT = 6;
  localparam int SLOT_PIN3 = 0;
  localparam int SLOT_PIN5 = 1;
  localparam int SLOT_PIN6 = 2;
  localparam int SLOT_PIN7 = 3;
  localparam int SLOT_PIN8 = 4;
  localparam int SLOT_SECOND_PIN3 = 5;

  typedef enum logic [1:0] {
    MODE_FUNCTIONAL = 2'h0,
    MODE_GP_OUTPUT = 2'h1,
    MODE_GP_INPUT = 2'h3,
    MODE_TRISTATE = 2'h2
  } gpcb_mode_type;

  // bit order matches the register nibble, value bit on top
  typedef struct packed {
    logic local_value;
    logic remote_ctrl;
    logic direction;
    logic general_enable;
  } gpcb_pin_cfg_type;

endpackage

// File: gpcb_remote_model.sv
// far serializer model: forwards pin values to the bank
// assumes the bench supplies the values to forward on clk
module gpcb_remote_model (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // values to forward
  input wire logic [gpcb_pkg::PIN_COUNT-1:0] send_value,
  output logic [gpcb_pkg::PIN_COUNT-1:0] remote_value
);
  timeunit 1ns;
  timeprecision 100ps;

  // one cycle of link latency, zero while the link is in reset
  always_ff @(posedge clk)
  begin
    remote_value <= nrst ? send_value : 6'h00;
  end
endmodule

// File: tb.sv
// testbench for the pin configuration bank
// assumes gpcb_pkg, gpcb_bank and gpcb_remote_model are compiled first
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk;
  logic nrst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic second_port_select;
  logic [5:0] func_value;
  logic [5:0] send_value;
  logic [5:0] remote_value;
  logic [5:0] pin_in;
  logic [5:0] pin_out;
  logic [5:0] pin_oe;
  logic [3:0] nib [6];
  int bad_count;
  int n_tests;

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  gpcb_bank gpcb_bank_inst (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .second_port_select(second_port_select),
    .func_value(func_value), .remote_value(remote_value),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

  gpcb_remote_model gpcb_remote_model_inst (.clk(clk), .nrst(nrst),
    .send_value(send_value), .remote_value(remote_value));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check("rdata", reg_rdata, exp);
  endtask

  // tri-state and input modes drive pin_out low, but only oe is compared there
  task automatic check_pins();
    logic [3:0] n;
    for (int i = 0; i < 6; i++)
    begin
      n = nib[i];
      if (n[2])
      begin
        check("oe", 8'(pin_oe[i]), 8'h01);
        check("out", 8'(pin_out[i]), 8'(remote_value[i]));
      end
      else if (n[1])
        check("oe", 8'(pin_oe[i]), 8'h00);
      else
      begin
        check("oe", 8'(pin_oe[i]), 8'h01);
        check("out", 8'(pin_out[i]),
              8'(n[0] ? n[3] : func_value[i]));
      end
    end
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5000) @(posedge clk);
    bad_count++;
    summarize();
  end

  initial
  begin
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    second_port_select = 1'b0;
    func_value = 6'h2a;
    send_value = 6'h15;
    pin_in = 6'h33;
    bad_count = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    nib = '{4'h2, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2};
    check_pins();
    rd(8'h1f, 8'h02);
    rd(8'h20, 8'h00);
    rd(8'h21, 8'h00);
    $display("reset test done");
    // every nibble code, upper and lower halves kept distinct
    for (int k = 0; k < 16; k++)
    begin
      send_value <= 6'(k * 11);
      func_value <= ~6'(k * 11);
      nib = '{4'h2, 4'(k), ~4'(k), ~4'(k), 4'(k), 4'h2};
      wr(8'h20, {nib[2], nib[1]});
      wr(8'h21, {nib[4], nib[3]});
      @(posedge clk);
      #1;
      check_pins();
      rd(8'h21, {nib[4], nib[3]});
      rd(8'h20, {nib[2], nib[1]});
    end
    $display("mode test done");
    second_port_select <= 1'b1;
    wr(8'h1f, 8'hf9);
    @(posedge clk);
    #1;
    nib[5] = 4'h9;
    check_pins();
    rd(8'h1f, 8'h09);
    second_port_select <= 1'b0;
    rd(8'h1f, 8'h02);
    // primary pin 3 under remote control, reserved bits dropped
    wr(8'h1f, 8'hf5);
    @(posedge clk);
    #1;
    nib[0] = 4'h5;
    check_pins();
    rd(8'h1f, 8'h05);
    rd(8'h30, 8'h00);
    rd(8'h24, {2'h0, pin_in});
    // a new level needs stages two and three to agree first
    pin_in <= 6'h0c;
    rd(8'h24, 8'h33);
    repeat (2) @(posedge clk);
    rd(8'h24, 8'h0c);
    // a one-cycle pulse never reaches the level register
    pin_in <= 6'h3f;
    @(posedge clk);
    pin_in <= 6'h0c;
    rd(8'h24, 8'h0c);
    rd(8'h24, 8'h0c);
    $display("second port test done");
    summarize();
  end
endmodule
